/* common/rioc_cfg.svh */
`ifndef RIOC_CFG_SVH
`define RIOC_CFG_SVH

// register byte offsets
`define RIOC_CTRL_OFS      12'h000
`define RIOC_IN_STAT_OFS   12'h004
`define RIOC_OUT_STAT_OFS  12'h008
`define RIOC_PAD_STAT_OFS  12'h00C

// control register fields
`define RIOC_CTRL_USE_BIT  0
`define RIOC_CTRL_OE_BIT   1
`define RIOC_CTRL_W        2

// control reset value: bypass selected, pad driver off
`define RIOC_CTRL_RST      2'h0

// bus answer values
`define RIOC_RDATA_ZERO    32'h0000_0000
`define RIOC_ADDR_W        12

`endif

/* common/rioc_pkg.sv */
package rioc_pkg;

  // apb slave phase
  typedef enum logic [1:0] {
    RIOC_IDLE,
    RIOC_SETUP,
    RIOC_ACCESS
  } rioc_phase_t;

endpackage : rioc_pkg

/* verilog/rioc_cell.sv */
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - full registers on input and output paths
// - output register loads only under load enable
// - use-select low bypasses output register to pad
// - clear-or-preset line forces both registers asynchronously
// - both registers clocked by one I/O clock
// - output register value returned to core array
// - I/O clock shared by I/O cell storage, APB slave and core array
`include "rioc_cfg.svh"

module rioc_cell
  import rioc_pkg::*;
#(
  parameter int  WIDTH       = 1,   // number of pad bits in the cell
  parameter bit  INIT_PRESET = 1'b0 // 1: init line presets, 0: clears
) (
  input  wire logic             pclk,              // io global clock
  input  wire logic             presetn,           // async reset, active low
  input  wire logic             io_init_clr_pre_n, // global clear-or-preset, active low
  input  wire logic [11:0]      paddr,             // apb byte address
  input  wire logic             psel,              // apb select
  input  wire logic             penable,           // apb enable
  input  wire logic             pwrite,            // apb direction
  input  wire logic [31:0]      pwdata,            // apb write data
  output logic      [31:0]      prdata,            // apb read data
  output logic                  pready,            // apb ready
  output logic                  pslverr,           // apb error
  input  wire logic [WIDTH-1:0] core_dout,         // array data toward pad
  input  wire logic             out_data_load_en,  // output register load enable
  output logic      [WIDTH-1:0] core_din,          // input register to array
  output logic      [WIDTH-1:0] core_fb,           // output register to array
  input  wire logic [WIDTH-1:0] pad_in,            // pad level seen by receiver
  output logic      [WIDTH-1:0] pad_out,           // pad driver data
  output logic      [WIDTH-1:0] pad_oe             // pad driver enable, high drives
);

  localparam logic [WIDTH-1:0] INIT_VAL = INIT_PRESET ? {WIDTH{1'b1}} : {WIDTH{1'b0}};

  // cell storage resets on either the chip reset or the global init line;
  // the release is not resynchronised, so it must stay clear of a clock edge
  logic cell_rst_n;
  assign cell_rst_n = presetn & io_init_clr_pre_n;

  // ---------------------------------------------------------------
  // input path
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] pad_meta_q;
  logic [WIDTH-1:0] pad_meta_d;
  logic [WIDTH-1:0] in_reg_q;
  logic [WIDTH-1:0] in_reg_d;

  always_comb begin
    pad_meta_d = pad_in;
    in_reg_d   = pad_meta_q;
  end

  // two flops stand between the pad and the array: the meta stage absorbs
  // a pad edge that lands close to the clock
  // the meta stage feeds only the input register
  always_ff @(posedge pclk or negedge cell_rst_n) begin
    if (!cell_rst_n) begin
      pad_meta_q <= INIT_VAL;
      in_reg_q   <= INIT_VAL;
    end else begin
      pad_meta_q <= pad_meta_d;
      in_reg_q   <= in_reg_d;
    end
  end

  // ---------------------------------------------------------------
  // output path
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] out_reg_q;
  logic [WIDTH-1:0] out_reg_d;

  // with the load enable low the word is kept, so a state loop closed
  // through core_fb sees a steady value
  always_comb begin
    out_reg_d = out_reg_q;
    if (out_data_load_en) begin
      out_reg_d = core_dout;
    end
  end

  always_ff @(posedge pclk or negedge cell_rst_n) begin
    if (!cell_rst_n) begin
      out_reg_q <= INIT_VAL;
    end else begin
      out_reg_q <= out_reg_d;
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  // bit 0 routes the output register to the pad, bit 1 turns the driver on;
  // the init line leaves both alone
  logic [`RIOC_CTRL_W-1:0] ctrl_q;
  logic [`RIOC_CTRL_W-1:0] ctrl_d;
  logic                    out_reg_use_sel;
  logic                    drv_en;

  assign out_reg_use_sel = ctrl_q[`RIOC_CTRL_USE_BIT];
  assign drv_en          = ctrl_q[`RIOC_CTRL_OE_BIT];

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  rioc_phase_t phase_q;
  rioc_phase_t phase_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;

  // decode of an address to a mapped register
  function automatic logic rioc_mapped(input logic [11:0] a);
    rioc_mapped = (a == `RIOC_CTRL_OFS)     ||
                  (a == `RIOC_IN_STAT_OFS)  ||
                  (a == `RIOC_OUT_STAT_OFS) ||
                  (a == `RIOC_PAD_STAT_OFS);
  endfunction : rioc_mapped

  // read mux, narrow fields in the low bits
  function automatic logic [31:0] rioc_read(input logic [11:0] a);
    logic [31:0] v;
    v = `RIOC_RDATA_ZERO;
    unique case (a)
      `RIOC_CTRL_OFS:     v[`RIOC_CTRL_W-1:0] = ctrl_q;
      `RIOC_IN_STAT_OFS:  v[WIDTH-1:0]        = in_reg_q;
      `RIOC_OUT_STAT_OFS: v[WIDTH-1:0]        = out_reg_q;
      `RIOC_PAD_STAT_OFS: v[WIDTH-1:0]        = pad_out;
      default:            v                   = `RIOC_RDATA_ZERO;
    endcase
    rioc_read = v;
  endfunction : rioc_read

  // zero wait states: every setup is answered in the access cycle after it;
  // writes to read-only words are dropped without an error
  always_comb begin
    phase_d   = phase_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    ctrl_d    = ctrl_q;
    unique case (phase_q)
      RIOC_IDLE: begin
        if (psel && !penable) begin
          // answer is prepared in setup so ready leaves a flop in access
          phase_d   = RIOC_ACCESS;
          pready_d  = 1'b1;
          pslverr_d = !rioc_mapped(paddr);
          prdata_d  = pwrite ? `RIOC_RDATA_ZERO : rioc_read(paddr);
        end
      end
      RIOC_ACCESS: begin
        phase_d = RIOC_IDLE;
        if (psel && penable && pready_q && pwrite && (paddr == `RIOC_CTRL_OFS)) begin
          ctrl_d = pwdata[`RIOC_CTRL_W-1:0];
        end
        prdata_d = `RIOC_RDATA_ZERO;
      end
      // never entered; falls back to idle should it ever be reached
      RIOC_SETUP: begin
        phase_d = RIOC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q   <= RIOC_IDLE;
      prdata_q  <= `RIOC_RDATA_ZERO;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      ctrl_q    <= `RIOC_CTRL_RST;
    end else begin
      phase_q   <= phase_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      ctrl_q    <= ctrl_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------
  // pad side driver enable
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] oe_q;
  logic [WIDTH-1:0] oe_d;

  // the enable lags its control bit by one edge so the pin sees a flop
  always_comb begin
    oe_d = {WIDTH{drv_en}};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q <= '0;
    end else begin
      oe_q <= oe_d;
    end
  end

  // ---------------------------------------------------------------
  // cell outputs
  // ---------------------------------------------------------------
  // bypass is a true combinational path so array data reaches the pad
  // without waiting for a clock edge
  assign pad_out  = out_reg_use_sel ? out_reg_q : core_dout;
  assign pad_oe   = oe_q;
  assign core_din = in_reg_q;
  assign core_fb  = out_reg_q;

endmodule : rioc_cell

/* tb/rioc_cell_sva.sv */
`timescale 1ns/1ps
module rioc_cell_sva
  import rioc_pkg::*;
#(parameter int WIDTH = 1, parameter bit INIT_PRESET = 1'b0) (
  input wire logic             pclk, // clock
  input wire logic             presetn, // reset
  input wire logic             io_init_clr_pre_n, // init
  input wire logic [11:0]      paddr, // addr
  input wire logic             psel, // sel
  input wire logic             penable, // enable
  input wire logic             pwrite, // dir
  input wire logic [31:0]      pwdata, // wdata
  input wire logic             pready, // ready
  input wire logic             pslverr, // error
  input wire logic [WIDTH-1:0] core_dout, // data
  input wire logic             out_data_load_en, // load
  input wire logic [WIDTH-1:0] core_din, // in reg
  input wire logic [WIDTH-1:0] core_fb, // out reg
  input wire logic [WIDTH-1:0] pad_in, // pad
  input wire logic [WIDTH-1:0] pad_out, // driver
  input wire logic [WIDTH-1:0] pad_oe // enable
);
  logic [1:0] c_q;
  wire run = presetn && io_init_clr_pre_n;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the control register
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) c_q <= 2'h0;
    else if (psel && penable && pready && pwrite && paddr == 12'h000) c_q <= pwdata[1:0];
  a_out_load: assert property (out_data_load_en && run ##1 run |-> core_fb == $past(core_dout))
    else $error("missed load");
  a_out_hold: assert property (!out_data_load_en && run ##1 run |-> $stable(core_fb))
    else $error("load without enable");
  a_in_pipe: assert property (run [*3] |-> core_din == $past(pad_in, 2))
    else $error("input path wrong");
  a_init_force: assert property (!io_init_clr_pre_n |-> core_fb == {WIDTH{INIT_PRESET}}
    && core_din == {WIDTH{INIT_PRESET}}) else $error("init not forced");
  a_pad_select: assert property (pad_out == (c_q[0] ? core_fb : core_dout))
    else $error("pad source wrong");
  a_oe_follow: assert property (pad_oe == {WIDTH{$past(c_q[1])}})
    else $error("drive enable wrong");
  a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready pulse wrong");
  a_unmapped_err: assert property (psel && !penable && paddr[11:4] != 8'h00 |=> pslverr)
    else $error("no error");
endmodule : rioc_cell_sva
bind rioc_cell rioc_cell_sva #(.WIDTH(WIDTH), .INIT_PRESET(INIT_PRESET)) u_sva (.*);

/* tb/rioc_pad_model.sv */
`timescale 1ns/1ps
module rioc_pad_model #(parameter int WIDTH = 4) (
  input  wire logic [WIDTH-1:0] pad_out, // cell data
  input  wire logic [WIDTH-1:0] pad_oe, // cell enable
  input  wire logic [WIDTH-1:0] board, // level when released, toggled or randomised each cycle
  output logic      [WIDTH-1:0] pad_in // resolved level
);
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board);
endmodule : rioc_pad_model

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  localparam int W = 4;
  logic pclk = '0, presetn = '0, init_n = '1, psel = '0, penable = '0, pwrite = '0;
  logic ld = '0, rnd = '0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [W-1:0] dout = '0, ext = '0, din, fb, pin, pout, poe, efb, em, ein, pseen;
  logic [1:0] ctl = '0;
  int fails = 0, checks_done = 0, cyc = 0;
  rioc_cell #(.WIDTH(W)) uut (.pclk(pclk), .presetn(presetn), .io_init_clr_pre_n(init_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_dout(dout),
    .out_data_load_en(ld), .core_din(din), .core_fb(fb), .pad_in(pin), .pad_out(pout),
    .pad_oe(poe));
  rioc_pad_model #(.WIDTH(W)) u_pad (.pad_out(pout), .pad_oe(poe), .board(ext), .pad_in(pin));
  initial forever #25 pclk = ~pclk; // array and io storage share this clock
  function automatic logic [W-1:0] pad_exp(input logic [1:0] c, input logic [W-1:0] f, d);
    return c[0] ? f : d;
  endfunction : pad_exp
  task automatic chk(input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("fails=%0d checks=%0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, er, input logic ee);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the cycle watchdog ends a wait that never sees ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk(pslverr, ee);
    if (!w) chk(prdata, er);
    if (w && a == 12'h000) ctl = d[1:0];
  endtask : apb
  // reference of the cell registers, same clock edges as the design
  always @(posedge pclk) begin
    if (!presetn || !init_n) {efb, em, ein} = '0;
    else begin
      if (ld) efb = dout;
      ein = em;
      em = pseen;
    end
    if (rnd) {dout, ld, ext} <= (2*W+1)'($urandom);
    else begin
      ld <= 1'b0;
      ext <= ~ext;
    end
    if (++cyc == 2000) begin
      fails++;
      report_and_stop();
    end
  end
  always @(negedge pclk) begin
    if (presetn && !init_n) begin
      chk(fb, '0);
      chk(din, '0);
    end else if (presetn) begin
      chk(fb, efb);
      chk(din, ein);
      chk(pout, pad_exp(ctl, efb, dout));
    end
    pseen = pin;
  end
  initial begin
    void'($urandom(32'hCFD5));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(12'h000, 1'b0, '0, 32'h0, 1'b0);
    apb(12'h010, 1'b0, '0, 32'h0, 1'b1);
    apb(12'h004, 1'b1, 32'hF, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      apb(12'h000, 1'b1, 32'(i), 32'h0, 1'b0);
      apb(12'h000, 1'b0, '0, 32'(i), 1'b0);
      {psel, penable, rnd} <= 3'h1;
      repeat (40) @(posedge pclk);
      rnd <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(12'h008, 1'b0, '0, 32'(efb), 1'b0);
      apb(12'h00C, 1'b0, '0, 32'(pad_exp(ctl, efb, dout)), 1'b0);
      if (i > 1) apb(12'h004, 1'b0, '0, 32'(pad_exp(ctl, efb, dout)), 1'b0);
    end
    {psel, penable, init_n} <= 3'h0;
    repeat (2) @(posedge pclk);
    init_n <= 1'b1;
    @(posedge pclk);
    apb(12'h000, 1'b0, '0, 32'h3, 1'b0);
    {psel, penable} <= 2'h0;
    repeat (4) @(posedge pclk);
    report_and_stop();
  end
endmodule : tb
